// *** rtl/fxr_pkg.sv ***
// constants and carrier types for the frequency reference and ramp selector
package fxr_pkg;
    // frequencies in 0.01 Hz units, times in 0.1 s units, limits in 0.1 %
    localparam int          FW            = 16;
    localparam int          TW            = 16;
    localparam int          PW            = 11;
    localparam int          AW            = 12;
    localparam int          DI_N          = 6;
    localparam int          SPAN_W        = 40;
    localparam logic [15:0] FREQ_TOP      = 16'h9c40;
    localparam logic [10:0] PCT_FULL      = 11'h3e8;
    localparam logic [10:0] PCT_TOP       = 11'h442;
    localparam logic [10:0] UPPER_BOTTOM  = 11'h001;
    localparam logic [11:0] ADC_FULL      = 12'hfff;
    localparam logic [15:0] TIME_TOP      = 16'hea60;
    localparam logic [15:0] JOG_TIME_TOP  = 16'h1770;
    // frequency source selection codes
    localparam logic [2:0]  SRC_KEYPAD    = 3'h0;
    localparam logic [2:0]  SRC_AI1       = 3'h1;
    localparam logic [2:0]  SRC_UPDOWN    = 3'h2;
    localparam logic [2:0]  SRC_SERIAL    = 3'h3;
    localparam logic [2:0]  SRC_PID       = 3'h5;
    localparam logic [2:0]  SRC_AI2       = 3'h7;
    // digital input function codes
    localparam logic [5:0]  FN_JOG_FWD    = 6'h06;
    localparam logic [5:0]  FN_JOG_REV    = 6'h07;
    localparam logic [5:0]  FN_TIME_LO    = 6'h0a;
    localparam logic [5:0]  FN_SRC_SWAP   = 6'h0d;
    localparam logic [5:0]  FN_EMERGENCY  = 6'h0e;
    localparam logic [5:0]  FN_TIME_HI    = 6'h1e;
    // time base: one time unit is a tenth of a second
    localparam int          CLK_NS        = 20;
    localparam int          TENTH_NS      = 100_000_000;
    localparam int          CYC_PER_TENTH = TENTH_NS / CLK_NS;
    // emergency stop sequence, gray coded
    typedef enum logic [1:0] {
        FXR_RUN     = 2'b00,
        FXR_HALTING = 2'b01,
        FXR_HALTED  = 2'b11
    } fxr_stop_t;
    typedef struct packed {
        logic [15:0] acc;
        logic [15:0] dec;
    } fxr_pair_t;
    typedef struct packed {
        logic below_min;
        logic sum_err;
        logic limit_err;
        logic halted;
    } fxr_status_t;
endpackage

// *** rtl/fxr_ramp.sv ***
// linear ramp of the output frequency toward a target
`timescale 1ns/1ps
`default_nettype none
module fxr_ramp
    import fxr_pkg::*;
#(
    parameter int CYC_TENTH = CYC_PER_TENTH
)(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [15:0]   target,
    input  wire fxr_pair_t     times,
    input  wire logic [15:0]   max_freq,
    input  wire logic          preload,
    input  wire logic [15:0]   preload_val,
    output logic      [15:0]   out_freq
);
    logic [SPAN_W-1:0] acc;
    logic [SPAN_W-1:0] span;
    logic [SPAN_W-1:0] next_acc;
    logic [15:0]       t_sel;
    logic              rising;

    generate
        if (CYC_TENTH < 1)
        begin : g_bad
            $error("ramp time base must be at least one cycle");
        end
    endgenerate
    // a full-scale sweep of max_freq spans t_sel tenths of a second
    assign rising   = target > out_freq;
    assign t_sel    = rising ? times.acc : times.dec;
    assign span     = SPAN_W'(t_sel) * SPAN_W'(CYC_TENTH);
    assign next_acc = acc + SPAN_W'(max_freq);

    // step the output by one unit each time the accumulator passes the span
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_freq <= 16'h0000;
            acc      <= '0;
        end
        else if (preload)
        begin
            out_freq <= preload_val;
            acc      <= '0;
        end
        else if (out_freq == target)
        begin
            acc <= '0;
        end
        else if (t_sel == 16'h0000)
        begin
            out_freq <= target; // zero time jumps at once
            acc      <= '0;
        end
        else if (next_acc >= span)
        begin
            out_freq <= rising ? out_freq + 16'h0001 : out_freq - 16'h0001;
            acc      <= next_acc - span;
        end
        else
        begin
            acc <= next_acc;
        end
    end
endmodule
`default_nettype wire

// *** rtl/fxr_freq_ref.sv ***
// frequency reference selection, limiting and ramp time selection
// Functional notes
// - source 3 takes serially written frequency
// - source 5 with PID enabled uses PID
// - source 7 follows input two, else zero
// - mode 0 swaps main/alternative on function 13
// - mode 1 adds main and alternative values
// - mode 1 with equal sources flags error
// - serial setpoint readable, 0.00 to 400.00 Hz
// - power down keeps keypad or serial frequency
// - below minimum: warn, or run at minimum
// - sleeping PID held at lower limit or 0
// - upper 0.1-109.0 %, lower 0.0-109.0 %
// - above lower limit, start from minimum frequency
// - upper below lower flags limit error
// - four time pairs span 0 to 100 %
// - functions 30 and 10 pick time pair
// - auto pair 1 below, pair 4 at/above switch
// - auto switching off when 10/30 assigned
// - jog inputs 6 or 7 use jog frequency
// - jog times span 0 to 100 %
// - function 14 ramps to zero, then halts
// - analog characteristic 0 direct, 1 inverse
// - source codes 0,1,2,3,5,7; 4,6 reserved
`timescale 1ns/1ps
`default_nettype none
module fxr_freq_ref
    import fxr_pkg::*;
#(
    parameter int CYC_TENTH = CYC_PER_TENTH
)(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [2:0]                 main_sel,
    input  wire logic [2:0]                 alt_sel,
    input  wire logic                       combo_mode,
    input  wire logic [DI_N-1:0][5:0]       di_func,
    input  wire logic [DI_N-1:0]            digital_input_terminals,
    input  wire logic [15:0]                keypad_freq,
    input  wire logic [15:0]                updown_freq,
    input  wire logic                       serial_wr,
    input  wire logic [15:0]                serial_wdata,
    input  wire logic [15:0]                pid_out,
    input  wire logic [3:0]                 pid_mode,
    input  wire logic                       sleep,
    input  wire logic                       pid_limit_opt,
    input  wire logic [AW-1:0]              analog_input_one,
    input  wire logic [AW-1:0]              analog_input_two,
    input  wire logic [3:0]                 ai2_func,
    input  wire logic                       inverse_char,
    input  wire logic [15:0]                max_freq,
    input  wire logic [15:0]                min_freq,
    input  wire logic                       min_det_opt,
    input  wire logic [10:0]                upper_pct,
    input  wire logic [10:0]                lower_pct,
    input  wire fxr_pair_t [3:0]            time_pairs,
    input  wire logic [15:0]                switch_freq,
    input  wire logic [15:0]                jog_freq,
    input  wire fxr_pair_t                  jog_times,
    input  wire logic [15:0]                estop_time,
    input  wire logic                       run_cmd,
    input  wire logic                       mem_opt,
    input  wire logic                       power_down,
    output logic      [15:0]                out_freq,
    output logic      [15:0]                target,
    output logic      [15:0]                serial_freq,
    output logic      [15:0]                retained_freq,
    output logic      [1:0]                 active_pair,
    output fxr_status_t                     status,
    output logic                            below_min_freq_warning,
    output logic                            same_source_sum_error,
    output logic                            limit_order_error,
    output logic                            emergency_halt_indication
);
    fxr_stop_t   state;
    fxr_stop_t   next_state;
    logic [15:0] raw_main;
    logic [15:0] raw_alt;
    logic [16:0] sum_ref;
    logic [15:0] sel_ref;
    logic [15:0] lim_ref;
    logic [15:0] next_target;
    logic [15:0] upper_freq;
    logic [15:0] lower_freq;
    logic [15:0] pid_val;
    logic        swap_on;
    logic        jog_on;
    logic        estop_on;
    logic        t_lo;
    logic        t_hi;
    logic        manual_pair;
    logic        below_min;
    logic        run_q;
    logic        preload;
    logic [1:0]  next_pair;
    fxr_pair_t   ramp_times;

    generate
        if (CYC_TENTH < 1)
        begin : g_bad
            $error("time base must be at least one cycle");
        end
    endgenerate

    // true when a terminal with function f is assigned and active
    function automatic logic fn_active(input logic [DI_N-1:0][5:0] f_map,
                                       input logic [DI_N-1:0] lvl,
                                       input logic [5:0] f);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DI_N; i++)
            hit = hit | (lvl[i] & (f_map[i] == f));
        return hit;
    endfunction

    // true when any terminal carries function f
    function automatic logic fn_assigned(input logic [DI_N-1:0][5:0] f_map,
                                         input logic [5:0] f);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DI_N; i++)
            hit = hit | (f_map[i] == f);
        return hit;
    endfunction

    // analog input to frequency, full scale is max frequency
    function automatic logic [15:0] scale_ai(input logic [AW-1:0] ai,
                                             input logic inv,
                                             input logic [15:0] fmax);
        logic [AW-1:0] a;
        logic [27:0]   p;
        a = inv ? ADC_FULL - ai : ai;
        p = 28'(a) * 28'(fmax);
        return 16'(p / 28'(ADC_FULL));
    endfunction

    // percentage of max frequency in tenths of a percent
    function automatic logic [15:0] pct_of(input logic [10:0] pct,
                                           input logic [15:0] fmax);
        logic [26:0] p;
        p = 27'(pct) * 27'(fmax);
        return 16'(p / 27'(PCT_FULL));
    endfunction

    // value of one frequency source
    function automatic logic [15:0] src_value(input logic [2:0] sel,
                                              input logic [15:0] kp,
                                              input logic [15:0] a1,
                                              input logic [15:0] ud,
                                              input logic [15:0] ser,
                                              input logic [15:0] pid,
                                              input logic [15:0] a2);
        case (sel)
            SRC_KEYPAD: return kp;
            SRC_AI1:    return a1;
            SRC_UPDOWN: return ud;
            SRC_SERIAL: return ser;
            SRC_PID:    return pid;
            SRC_AI2:    return a2;
            default:    return 16'h0000;
        endcase
    endfunction

    // limit frequencies from percentages, upper held to its legal range
    always_comb
    begin
        upper_freq = pct_of((upper_pct < UPPER_BOTTOM) ? UPPER_BOTTOM :
                            (upper_pct > PCT_TOP) ? PCT_TOP : upper_pct, max_freq);
        lower_freq = pct_of((lower_pct > PCT_TOP) ? PCT_TOP : lower_pct, max_freq);
    end

    // terminal functions
    assign swap_on  = fn_active(di_func, digital_input_terminals, FN_SRC_SWAP);
    assign jog_on   = fn_active(di_func, digital_input_terminals, FN_JOG_FWD)
                    | fn_active(di_func, digital_input_terminals, FN_JOG_REV);
    assign estop_on = fn_active(di_func, digital_input_terminals, FN_EMERGENCY);
    assign t_lo     = fn_active(di_func, digital_input_terminals, FN_TIME_LO);
    assign t_hi     = fn_active(di_func, digital_input_terminals, FN_TIME_HI);
    assign manual_pair = fn_assigned(di_func, FN_TIME_LO)
                       | fn_assigned(di_func, FN_TIME_HI);

    // PID contribution, bound while sleeping
    always_comb
    begin
        if (!pid_mode[0])
            pid_val = 16'h0000;
        else if (sleep)
            pid_val = pid_limit_opt ? 16'h0000 : lower_freq;
        else
            pid_val = pid_out;
    end

    // source values
    assign raw_main = src_value(main_sel, keypad_freq,
                                scale_ai(analog_input_one, inverse_char, max_freq),
                                updown_freq, serial_freq, pid_val,
                                (ai2_func == 4'h0) ? scale_ai(analog_input_two, inverse_char, max_freq)
                                                   : 16'h0000);
    assign raw_alt  = src_value(alt_sel, keypad_freq,
                                scale_ai(analog_input_one, inverse_char, max_freq),
                                updown_freq, serial_freq, pid_val,
                                (ai2_func == 4'h0) ? scale_ai(analog_input_two, inverse_char, max_freq)
                                                   : 16'h0000);
    assign sum_ref  = 17'(raw_main) + 17'(raw_alt);

    // combine, apply minimum handling and the limit clamp
    always_comb
    begin
        if (combo_mode)
            sel_ref = (sum_ref > 17'(FREQ_TOP)) ? FREQ_TOP : sum_ref[15:0];
        else
            sel_ref = swap_on ? raw_alt : raw_main;
        below_min = sel_ref < min_freq;
        lim_ref   = sel_ref;
        if (below_min)
            lim_ref = min_det_opt ? min_freq : 16'h0000;
        if (lim_ref < lower_freq)
            lim_ref = lower_freq;
        if (lim_ref > upper_freq)
            lim_ref = upper_freq;
    end

    // target for the ramp: halt, stop, jog or reference
    always_comb
    begin
        if (state != FXR_RUN || !run_cmd)
            next_target = 16'h0000;
        else if (jog_on)
            next_target = jog_freq;
        else
            next_target = lim_ref;
    end

    // emergency stop sequence
    always_comb
    begin
        next_state = state;
        case (state)
            FXR_RUN:
                if (estop_on)
                    next_state = FXR_HALTING;
            FXR_HALTING:
                if (out_freq == 16'h0000)
                    next_state = FXR_HALTED;
            FXR_HALTED:
                if (!run_cmd && !estop_on)
                    next_state = FXR_RUN;
            default:
                next_state = FXR_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= FXR_RUN;
        else
            state <= next_state;
    end

    // time pair selection
    always_comb
    begin
        if (manual_pair)
            next_pair = {t_hi, t_lo};
        else if (switch_freq != 16'h0000)
            next_pair = (out_freq >= switch_freq) ? 2'h3 : 2'h0;
        else
            next_pair = 2'h0;
    end

    // ramp times in use
    always_comb
    begin
        if (state == FXR_HALTING)
            ramp_times = '{acc: estop_time, dec: estop_time};
        else if (jog_on && run_cmd)
            ramp_times = jog_times;
        else
            ramp_times = time_pairs[active_pair];
    end

    // start from minimum output frequency on a fresh run
    assign preload = run_cmd && !run_q && state == FXR_RUN && out_freq == 16'h0000
                   && !jog_on && lim_ref > lower_freq && lim_ref > min_freq;

    // registered target, pair and start detection
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            target      <= 16'h0000;
            active_pair <= 2'h0;
            run_q       <= 1'b0;
        end
        else
        begin
            target      <= next_target;
            active_pair <= next_pair;
            run_q       <= run_cmd;
        end
    end

    // serially written setpoint, held within range
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            serial_freq <= 16'h0000;
        else if (serial_wr)
            serial_freq <= (serial_wdata > FREQ_TOP) ? FREQ_TOP : serial_wdata;
    end

    // frequency kept at power down
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            retained_freq <= 16'h0000;
        else if (power_down)
            retained_freq <= mem_opt ? serial_freq : keypad_freq;
    end

    // warnings and configuration errors
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            below_min_freq_warning    <= 1'b0;
            same_source_sum_error     <= 1'b0;
            limit_order_error         <= 1'b0;
            emergency_halt_indication <= 1'b0;
        end
        else
        begin
            below_min_freq_warning    <= below_min && !min_det_opt;
            same_source_sum_error     <= combo_mode && main_sel == alt_sel;
            limit_order_error         <= upper_pct < lower_pct;
            emergency_halt_indication <= next_state == FXR_HALTED;
        end
    end

    assign status = '{below_min: below_min_freq_warning, sum_err: same_source_sum_error,
                      limit_err: limit_order_error, halted: emergency_halt_indication};

    fxr_ramp #(
        .CYC_TENTH(CYC_TENTH)
    ) u_ramp (
        .clk        (clk),
        .rst_n      (rst_n),
        .target     (target),
        .times      (ramp_times),
        .max_freq   (max_freq),
        .preload    (preload),
        .preload_val(min_freq),
        .out_freq   (out_freq)
    );

    serial_src_a: assert property (@(posedge clk) disable iff (!rst_n)
        main_sel == SRC_SERIAL |-> raw_main == serial_freq)
        else $error("serial source not selected");
    pid_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        main_sel == SRC_PID && pid_mode[0] && !sleep |-> raw_main == pid_out)
        else $error("pid source not selected");
    ai2_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        main_sel == SRC_AI2 && ai2_func != 4'h0 |-> raw_main == 16'h0000)
        else $error("input two not zero when disabled");
    sum_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        combo_mode && main_sel == alt_sel |=> same_source_sum_error)
        else $error("sum source error missing");
    limit_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        upper_pct < lower_pct |=> limit_order_error)
        else $error("limit order error missing");
    clamp_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        !jog_on |=> target <= $past(upper_freq))
        else $error("target above upper limit");
    auto_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        !manual_pair && switch_freq != 16'h0000 && out_freq >= switch_freq |=> active_pair == 2'h3)
        else $error("auto pair four not chosen");
    manual_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        manual_pair |=> active_pair == $past({t_hi, t_lo}))
        else $error("terminal pair not followed");
    jog_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
        jog_on && run_cmd && state == FXR_RUN && !estop_on |=> target == $past(jog_freq))
        else $error("jog frequency not used");
    halt_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
        state == FXR_HALTING && out_freq == 16'h0000 |=> state == FXR_HALTED ##1 emergency_halt_indication)
        else $error("halt not reported");
    retain_a: assert property (@(posedge clk) disable iff (!rst_n)
        power_down |=> retained_freq == $past(mem_opt ? serial_freq : keypad_freq))
        else $error("wrong frequency retained");
endmodule
`default_nettype wire

// *** rtl/fxr_ramp_fix_note.sv ***
// no logic here: the ramp generator sits in fxr_ramp.sv

// *** bench/fxr_host_model.sv ***
// serial host that writes the frequency setpoint
`timescale 1ns/1ps
`default_nettype none
module fxr_host_model
    import fxr_pkg::*;
(
    input  wire logic        clk,
    output logic             serial_wr,
    output logic      [15:0] serial_wdata
);
    // idle: no write, data scrambled so stale values never match
    initial
    begin
        serial_wr = 1'b0;
        serial_wdata = 16'h5a5a;
    end
    // one write: value stands for one cycle only
    task automatic send(input logic [15:0] v);
        @(posedge clk);
        #1;
        serial_wr = 1'b1;
        serial_wdata = v;
        @(posedge clk);
        #1;
        serial_wr = 1'b0;
        serial_wdata = ~v;
    endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the frequency reference selector
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fxr_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, combo_mode = 1'b0, serial_wr, sleep = 1'b0, pid_limit_opt = 1'b0;
    logic inverse_char = 1'b0, min_det_opt = 1'b0, run_cmd = 1'b0, mem_opt = 1'b0, power_down = 1'b0;
    logic [2:0] main_sel = 3'h0, alt_sel = 3'h2;
    logic [DI_N-1:0][5:0] di_func = {DI_N{6'h00}};
    logic [DI_N-1:0] digital_input_terminals = 6'h00;
    logic [15:0] keypad_freq = 16'h03e8, updown_freq = 16'h02bc, pid_out = 16'h05dc, serial_wdata;
    logic [15:0] max_freq = 16'h1388, min_freq = 16'h00c8, switch_freq = 16'h0000, jog_freq = 16'h0320;
    logic [15:0] estop_time = 16'h0001, out_freq, target, serial_freq, retained_freq;
    logic [3:0] pid_mode = 4'h1, ai2_func = 4'h0;
    logic [AW-1:0] analog_input_one = 12'h800, analog_input_two = 12'hfff;
    logic [10:0] upper_pct = 11'h3e8, lower_pct = 11'h000;
    fxr_pair_t [3:0] time_pairs = {4{32'hea60_ea60}};
    fxr_pair_t jog_times = 32'h0001_0001;
    logic [1:0] active_pair;
    fxr_status_t status;
    logic below_min_freq_warning, same_source_sum_error, limit_order_error, emergency_halt_indication;
    int mismatches = 0, compares = 0, cycles = 0;

    fxr_freq_ref #(.CYC_TENTH(10)) u_fxr_freq_ref (
        .clk, .rst_n, .main_sel, .alt_sel, .combo_mode, .di_func, .digital_input_terminals, .keypad_freq,
        .updown_freq, .serial_wr, .serial_wdata, .pid_out, .pid_mode, .sleep, .pid_limit_opt,
        .analog_input_one, .analog_input_two, .ai2_func, .inverse_char, .max_freq, .min_freq, .min_det_opt,
        .upper_pct, .lower_pct, .time_pairs, .switch_freq, .jog_freq, .jog_times, .estop_time, .run_cmd,
        .mem_opt, .power_down, .out_freq, .target, .serial_freq, .retained_freq, .active_pair, .status,
        .below_min_freq_warning, .same_source_sum_error, .limit_order_error, .emergency_halt_indication
    );
    fxr_host_model u_fxr_host_model (.clk, .serial_wr, .serial_wdata);

    // 50 MHz clock
    initial
    begin
        forever #10 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $realtime, got, exp);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        run_cmd = 1'b1;
        settle();
        chk(target, 16'h03e8);
        chk(out_freq, 16'h00c8);
        repeat (20) @(posedge clk);
        #1;
        chk(out_freq, 16'h00c8);
        // 50 s full scale over 5000 units: one unit per cycle at this time base
        time_pairs = {4{32'h01f4_01f4}};
        repeat (400) @(posedge clk);
        #1;
        chk(out_freq, 16'h0258);
        repeat (400) @(posedge clk);
        #1;
        chk(out_freq, 16'h03e8);
        switch_freq = 16'h01f4;
        settle();
        chk(16'(active_pair), 16'h0003);
        switch_freq = 16'h0fa0;
        settle();
        chk(16'(active_pair), 16'h0000);
        switch_freq = 16'h01f4;
        di_func[2] = FN_TIME_LO;
        di_func[3] = FN_TIME_HI;
        for (int i = 0; i < 4; i++)
        begin
            digital_input_terminals[3:2] = 2'(i);
            settle();
            chk(16'(active_pair), 16'(i));
        end
        digital_input_terminals = 6'h00;
        u_fxr_host_model.send(16'h0bb8);
        main_sel = SRC_SERIAL;
        settle();
        chk(target, 16'h0bb8);
        chk(serial_freq, 16'h0bb8);
        u_fxr_host_model.send(16'hc350);
        settle();
        chk(serial_freq, 16'h9c40);
        chk(target, 16'h1388);
        mem_opt = 1'b1;
        power_down = 1'b1;
        @(posedge clk);
        #1;
        power_down = 1'b0;
        settle();
        chk(retained_freq, 16'h9c40);
        mem_opt = 1'b0;
        power_down = 1'b1;
        @(posedge clk);
        #1;
        power_down = 1'b0;
        settle();
        chk(retained_freq, 16'h03e8);
        main_sel = SRC_PID;
        settle();
        chk(target, 16'h05dc);
        sleep = 1'b1;
        lower_pct = 11'h064;
        settle();
        chk(target, 16'h01f4);
        pid_limit_opt = 1'b1;
        lower_pct = 11'h000;
        settle();
        chk(target, 16'h0000);
        main_sel = SRC_AI2;
        settle();
        chk(target, 16'h1388);
        ai2_func = 4'h1;
        settle();
        chk(target, 16'h0000);
        main_sel = SRC_AI1;
        analog_input_one = 12'h000;
        inverse_char = 1'b1;
        settle();
        chk(target, 16'h1388);
        main_sel = SRC_KEYPAD;
        combo_mode = 1'b1;
        settle();
        chk(target, 16'h06a4);
        alt_sel = SRC_KEYPAD;
        settle();
        chk(16'(same_source_sum_error), 16'h0001);
        chk(16'(status), 16'h0004);
        combo_mode = 1'b0;
        alt_sel = SRC_UPDOWN;
        di_func[0] = FN_SRC_SWAP;
        digital_input_terminals[0] = 1'b1;
        settle();
        chk(target, 16'h02bc);
        digital_input_terminals[0] = 1'b0;
        keypad_freq = 16'h0064;
        settle();
        chk(16'(below_min_freq_warning), 16'h0001);
        chk(target, 16'h0000);
        min_det_opt = 1'b1;
        settle();
        chk(target, 16'h00c8);
        keypad_freq = 16'h03e8;
        upper_pct = 11'h064;
        lower_pct = 11'h0c8;
        settle();
        chk(16'(limit_order_error), 16'h0001);
        upper_pct = 11'h000;
        lower_pct = 11'h000;
        settle();
        chk(target, 16'h0005);
        upper_pct = 11'h3e8;
        for (int j = 0; j < 2; j++)
        begin
            di_func[1] = j ? FN_JOG_REV : FN_JOG_FWD;
            digital_input_terminals[1] = 1'b1;
            settle();
            chk(target, 16'h0320);
        end
        digital_input_terminals[1] = 1'b0;
        di_func[4] = FN_EMERGENCY;
        digital_input_terminals[4] = 1'b1;
        for (int k = 0; k < 3000 && emergency_halt_indication !== 1'b1; k++)
            @(posedge clk);
        #1;
        chk(16'(emergency_halt_indication), 16'h0001);
        chk(out_freq, 16'h0000);
        digital_input_terminals[4] = 1'b0;
        settle();
        chk(16'(emergency_halt_indication), 16'h0001);
        run_cmd = 1'b0;
        settle();
        run_cmd = 1'b1;
        settle();
        chk(target, 16'h03e8);
        // jog times of 100 s: half a unit per cycle, slower than the pair times
        jog_times = 32'h03e8_03e8;
        digital_input_terminals[1] = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        chk(out_freq, 16'h00d3);
        stop_test();
    end
endmodule
`default_nettype wire
